// ===== hw/spx_pkg.sv
package spx_pkg;
   // Opcodes handled by this block (inherent addressing only)
   localparam logic [7:0] OPC_PUSH_A  = 8'h36;
   localparam logic [7:0] OPC_PUSH_B  = 8'h37;
   localparam logic [7:0] OPC_PUSH_CC = 8'h39;
   localparam logic [7:0] OPC_PUSH_D  = 8'h3b;
   localparam logic [7:0] OPC_PUSH_X  = 8'h34;
   localparam logic [7:0] OPC_PUSH_Y  = 8'h35;
   localparam logic [7:0] OPC_POP_A   = 8'h32;
   localparam logic [7:0] OPC_POP_B   = 8'h33;
   // Pointer steps
   localparam logic [15:0] STEP_ONE   = 16'h0001;
   localparam logic [15:0] STEP_TWO   = 16'h0002;
   // Reset values
   localparam logic [15:0] SP_RESET   = 16'h0000;
   localparam logic [7:0]  BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      SPX_IDLE  = 4'b0001,
      SPX_WRITE = 4'b0010,
      SPX_READ  = 4'b0100,
      SPX_LOAD  = 4'b1000
   } spx_state_type;
endpackage

// ===== hw/spx_sync.sv
`timescale 1ns/10ps
// Two-flop reset release, asserts asynchronously
module spx_sync (
   input  wire logic clk,
   input  wire logic arst_n,
   output logic      srst_n
);
   logic meta_q; // First stage, read only by second
   // Release through two stages
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'b0;
         srst_n <= 1'b0;
      end else begin
         meta_q <= 1'b1;
         srst_n <= meta_q;
      end
   end
endmodule

// ===== hw/spx_stack_push_pull_exec.sv
`timescale 1ns/10ps
// Overview of operation
// - 36 lowers pointer one, stores accumulator A
// - 37 lowers pointer one, stores accumulator B
// - 39 lowers pointer one, stores condition codes
// - 3B lowers pointer two, stores A then B
// - After double push pointer addresses A byte
// - 34 lowers pointer two, stores first pointer
// - 35 lowers pointer two, stores second pointer
// - 32 loads A from top, raises pointer
// - 33 loads B from top, raises pointer
module spx_stack_push_pull_exec
   import spx_pkg::*;
(
   input  wire logic         mclk,          // System clock, 40 MHz
   input  wire logic         rst_n,         // Asynchronous reset, active low
   input  wire logic         op_valid,      // Opcode offered
   input  wire logic [7:0]   op_code,       // Opcode byte
   input  wire logic [7:0]   accum_a_in,    // Accumulator A value
   input  wire logic [7:0]   accum_b_in,    // Accumulator B value
   input  wire logic [15:0]  ptr_x_in,      // First index register
   input  wire logic [15:0]  ptr_y_in,      // Second index register
   input  wire logic [7:0]   flags_in,      // Condition code register
   input  wire logic [7:0]   mem_rdata,     // Read data, same cycle as read strobe
   output logic              op_ready,      // Idle, may take an opcode
   output logic              op_done,       // Opcode finished pulse
   output logic              op_illegal,    // Opcode not ours pulse
   output logic [15:0]       stack_pointer, // Stack pointer register
   output logic              mem_we,        // Write strobe
   output logic              mem_re,        // Read strobe
   output logic              mem_wide,      // Write is 16-bit big-endian
   output logic [15:0]       mem_addr,      // Byte address
   output logic [15:0]       mem_wdata,     // Write data, byte in low bits
   output logic              acc_a_we,      // Load A strobe
   output logic              acc_b_we,      // Load B strobe
   output logic [7:0]        acc_load_data, // Pulled byte
   output logic [7:0]        flags_out      // Condition codes, untouched
);
   import spx_pkg::*;

   logic          srst_n;  // Synchronised reset
   spx_state_type state_q; // Sequencer state
   logic          pop_b_q; // Pull targets B

   // Reset release
   spx_sync u_rst (
      .clk    (mclk),
      .arst_n (rst_n),
      .srst_n (srst_n)
   );

   // Decode helpers
   logic is_push1;
   logic is_push2;
   logic is_pop;
   logic take;
   assign is_push1 = (op_code == OPC_PUSH_A) || (op_code == OPC_PUSH_B) ||
                     (op_code == OPC_PUSH_CC);
   assign is_push2 = (op_code == OPC_PUSH_D) || (op_code == OPC_PUSH_X) ||
                     (op_code == OPC_PUSH_Y);
   assign is_pop   = (op_code == OPC_POP_A) || (op_code == OPC_POP_B);
   assign take     = op_valid && (state_q == SPX_IDLE);

   // Sequencer
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         state_q <= SPX_IDLE;
      end else begin
         case (state_q)
            SPX_IDLE: begin
               if (take && (is_push1 || is_push2)) begin
                  state_q <= SPX_WRITE;
               end else if (take && is_pop) begin
                  state_q <= SPX_READ;
               end
            end
            SPX_WRITE: state_q <= SPX_IDLE;
            SPX_READ:  state_q <= SPX_LOAD;
            SPX_LOAD:  state_q <= SPX_IDLE;
            default:   state_q <= SPX_IDLE;
         endcase
      end
   end

   // Stack pointer: lowered before write, raised after read
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         stack_pointer <= SP_RESET;
      end else if (take && is_push1) begin
         stack_pointer <= stack_pointer - STEP_ONE;
      end else if (take && is_push2) begin
         stack_pointer <= stack_pointer - STEP_TWO;
      end else if (state_q == SPX_LOAD) begin
         stack_pointer <= stack_pointer + STEP_ONE;
      end
   end

   // Memory strobes and data
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         mem_we    <= 1'b0;
         mem_re    <= 1'b0;
         mem_wide  <= 1'b0;
         mem_addr  <= WORD_RESET;
         mem_wdata <= WORD_RESET;
      end else begin
         mem_we   <= 1'b0;
         mem_re   <= 1'b0;
         mem_wide <= 1'b0;
         if (take && is_push1) begin
            // Write at the lowered pointer
            mem_we   <= 1'b1;
            mem_addr <= stack_pointer - STEP_ONE;
            case (op_code)
               OPC_PUSH_A: mem_wdata <= {BYTE_RESET, accum_a_in};
               OPC_PUSH_B: mem_wdata <= {BYTE_RESET, accum_b_in};
               default:    mem_wdata <= {BYTE_RESET, flags_in};
            endcase
         end else if (take && is_push2) begin
            // High byte at lower address, big-endian
            mem_we   <= 1'b1;
            mem_wide <= 1'b1;
            mem_addr <= stack_pointer - STEP_TWO;
            case (op_code)
               OPC_PUSH_D: mem_wdata <= {accum_a_in, accum_b_in};
               OPC_PUSH_X: mem_wdata <= ptr_x_in;
               default:    mem_wdata <= ptr_y_in;
            endcase
         end else if (take && is_pop) begin
            // Read at current pointer
            mem_re   <= 1'b1;
            mem_addr <= stack_pointer;
         end
      end
   end

   // Pull target and accumulator load
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         pop_b_q       <= 1'b0;
         acc_a_we      <= 1'b0;
         acc_b_we      <= 1'b0;
         acc_load_data <= BYTE_RESET;
      end else begin
         acc_a_we <= 1'b0;
         acc_b_we <= 1'b0;
         if (take && is_pop) begin
            pop_b_q <= (op_code == OPC_POP_B);
         end
         if (state_q == SPX_READ) begin
            acc_load_data <= mem_rdata;
            acc_a_we      <= !pop_b_q;
            acc_b_we      <= pop_b_q;
         end
      end
   end

   // Handshake and status
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         op_ready   <= 1'b0;
         op_done    <= 1'b0;
         op_illegal <= 1'b0;
         flags_out  <= BYTE_RESET;
      end else begin
         op_done    <= take && (is_push1 || is_push2) || (state_q == SPX_READ);
         op_illegal <= take && !(is_push1 || is_push2 || is_pop);
         op_ready   <= (state_q == SPX_IDLE) && !take || (state_q == SPX_LOAD)
                       || (state_q == SPX_WRITE);
         flags_out  <= flags_in;
      end
   end

   // Assertions
   push_one_sp_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && is_push1 |=> stack_pointer == $past(stack_pointer) - STEP_ONE)
      else $error("single push did not lower pointer by one");
   push_two_sp_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && is_push2 |=> stack_pointer == $past(stack_pointer) - STEP_TWO)
      else $error("double push did not lower pointer by two");
   push_addr_a: assert property (@(posedge mclk) disable iff (!srst_n)
      mem_we |-> mem_addr == stack_pointer)
      else $error("write not at new pointer");
   push_a_data_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_PUSH_A |=> mem_we && mem_wdata[7:0] == $past(accum_a_in))
      else $error("A byte wrong");
   push_b_data_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_PUSH_B |=> mem_we && mem_wdata[7:0] == $past(accum_b_in))
      else $error("B byte wrong");
   push_cc_data_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_PUSH_CC |=> mem_we && mem_wdata[7:0] == $past(flags_in))
      else $error("flag byte wrong");
   push_d_order_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_PUSH_D |=> mem_wide && mem_wdata[15:8] == $past(accum_a_in))
      else $error("A not at lower address");
   push_d_low_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_PUSH_D |=> mem_wdata[7:0] == $past(accum_b_in))
      else $error("B not at higher address");
   push_d_top_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_PUSH_D |=> mem_we && mem_addr == stack_pointer)
      else $error("pointer not at stacked A byte");
   push_x_data_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_PUSH_X |=> mem_wdata == $past(ptr_x_in))
      else $error("first pointer data wrong");
   push_y_data_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_PUSH_Y |=> mem_wdata == $past(ptr_y_in))
      else $error("second pointer data wrong");
   pop_addr_a: assert property (@(posedge mclk) disable iff (!srst_n)
      mem_re |-> mem_addr == stack_pointer && !mem_we)
      else $error("read not at current pointer");
   pop_a_seq_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_POP_A |=> mem_re ##1 acc_a_we && !acc_b_we
      ##1 stack_pointer == $past(stack_pointer, 3) + STEP_ONE)
      else $error("pull A sequence wrong");
   pop_b_seq_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && op_code == OPC_POP_B |=> mem_re ##1 acc_b_we && !acc_a_we)
      else $error("pull B sequence wrong");
   illegal_quiet_a: assert property (@(posedge mclk) disable iff (!srst_n)
      take && !(is_push1 || is_push2 || is_pop) |=> !mem_we && !mem_re
      && stack_pointer == $past(stack_pointer))
      else $error("unhandled opcode touched stack");
   flags_kept_a: assert property (@(posedge mclk) disable iff (!srst_n)
      1'b1 |=> flags_out == $past(flags_in))
      else $error("condition codes altered");
endmodule

// ===== tb/spx_mem_model.sv
`timescale 1ns/10ps
// Stack memory, combinational byte read, byte or big-endian word write
module spx_mem_model (
   input  wire logic        mclk,
   input  wire logic        mem_we,
   input  wire logic        mem_re,
   input  wire logic        mem_wide,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata_hi,
   input  wire logic [7:0]  mem_wdata_lo,
   output logic      [7:0]  mem_rdata
);
   logic [7:0] mem_q [0:255];  // Low address byte selects a cell
   logic [7:0] last_q;         // Last byte driven
   // Writes, high byte at lower address
   always_ff @(posedge mclk) begin
      if (mem_we && mem_wide) begin
         mem_q[mem_addr[7:0]] <= mem_wdata_hi;
         mem_q[8'(mem_addr[7:0] + 8'h01)] <= mem_wdata_lo;
      end else if (mem_we) begin
         mem_q[mem_addr[7:0]] <= mem_wdata_lo;
      end
      // Remember the byte of the last read only
      if (mem_re) begin
         last_q <= mem_rdata;
      end
   end
   // Outside reads the bus shows the inverse of its last value
   always_comb begin
      mem_rdata = mem_re ? mem_q[mem_addr[7:0]] : ~last_q;
   end
endmodule

// ===== tb/stack_push_pull_exec_tb_top.sv
`timescale 1ns/10ps
module stack_push_pull_exec_tb_top;
   import spx_pkg::*;
   logic mclk, rst_n, op_valid, op_ready, op_done, op_illegal, mem_we, mem_re, mem_wide;
   logic acc_a_we, acc_b_we;
   logic [7:0]  op_code, mem_rdata, acc_load_data, flags_out, flags_in;
   logic [15:0] stack_pointer, mem_addr, mem_wdata;
   logic [15:0] addr_s, data_s, ptr_s;  // Captured per operation
   logic        wide_s, we_s, ill_s;
   logic [2:0]  ld_s;                    // Read seen, load A, load B
   logic [15:0] ld_exp;                  // Expected load pattern
   logic [7:0]  accum_a, accum_b;        // Accumulator values offered
   logic [15:0] ptr_x, ptr_y;            // Index register values offered
   int n_fail = 0;
   int checked = 0;
   // Row: opcode, pointer after, address used, word written or byte loaded, wide
   logic [56:0] rows [13] = '{
      {8'h36,16'hffff,16'hffff,16'h0011,1'b0}, {8'h37,16'hfffe,16'hfffe,16'h0022,1'b0},
      {8'h39,16'hfffd,16'hfffd,16'h00d5,1'b0}, {8'h3b,16'hfffb,16'hfffb,16'h1122,1'b1},
      {8'h34,16'hfff9,16'hfff9,16'h3344,1'b1}, {8'h35,16'hfff7,16'hfff7,16'h5566,1'b1},
      {8'h32,16'hfff8,16'hfff7,16'h0055,1'b0}, {8'h33,16'hfff9,16'hfff8,16'h0066,1'b0},
      {8'h32,16'hfffa,16'hfff9,16'h0033,1'b0}, {8'h33,16'hfffb,16'hfffa,16'h0044,1'b0},
      {8'h32,16'hfffc,16'hfffb,16'h0011,1'b0}, {8'h33,16'hfffd,16'hfffc,16'h0022,1'b0},
      {8'h32,16'hfffe,16'hfffd,16'h00d5,1'b0}};
   spx_stack_push_pull_exec dut (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid),
      .op_code(op_code), .accum_a_in(accum_a), .accum_b_in(accum_b), .ptr_x_in(ptr_x),
      .ptr_y_in(ptr_y), .flags_in(flags_in), .mem_rdata(mem_rdata), .op_ready(op_ready),
      .op_done(op_done), .op_illegal(op_illegal), .stack_pointer(stack_pointer),
      .mem_we(mem_we), .mem_re(mem_re), .mem_wide(mem_wide), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .acc_a_we(acc_a_we), .acc_b_we(acc_b_we),
      .acc_load_data(acc_load_data), .flags_out(flags_out));
   spx_mem_model mem (.mclk(mclk), .mem_we(mem_we), .mem_re(mem_re), .mem_wide(mem_wide),
      .mem_addr(mem_addr), .mem_wdata_hi(mem_wdata[15:8]), .mem_wdata_lo(mem_wdata[7:0]),
      .mem_rdata(mem_rdata));
   // Clock, 25 ns period
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict
   task automatic results();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Offer one opcode, capture its bus traffic, wait until idle again
   task automatic run(input logic [7:0] op);
      int k;
      we_s = 1'b0;
      ill_s = 1'b0;
      ld_s = 3'b000;
      @(posedge mclk);
      op_valid <= 1'b1;
      op_code  <= op;
      @(posedge mclk);
      op_valid <= 1'b0;
      for (k = 0; k < 8; k++) begin
         @(negedge mclk);
         if (mem_we === 1'b1) we_s = 1'b1;
         if (mem_re === 1'b1) ld_s[2] = 1'b1;
         if (op_done === 1'b1) ld_s[1:0] = {acc_a_we, acc_b_we};
         if (mem_we === 1'b1 || mem_re === 1'b1) begin
            addr_s = mem_addr;
            wide_s = mem_wide;
            data_s = mem_wdata;
         end
         if (op_done === 1'b1) data_s = (we_s) ? data_s : {8'h00, acc_load_data};
         if (op_illegal === 1'b1) ill_s = 1'b1;
         if (op_done === 1'b1 || op_illegal === 1'b1) break;
      end
      if (k == 8) begin
         n_fail++;
         $display("[ERR] %0t no completion", $time);
      end
      repeat (2) @(posedge mclk);
      #1 ptr_s = stack_pointer;
   endtask
   initial begin
      rst_n = 1'b0;
      op_valid = 1'b0;
      op_code = 8'h00;
      flags_in = 8'hd5;
      accum_a = 8'h11;
      accum_b = 8'h22;
      ptr_x = 16'h3344;
      ptr_y = 16'h5566;
      repeat (5) @(posedge mclk);
      #1 chk(stack_pointer, SP_RESET);
      chk({15'h0, op_ready}, 16'h0000);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk({15'h0, op_ready}, 16'h0001);
      foreach (rows[i]) begin
         run(rows[i][56:49]);
         chk(ptr_s, rows[i][48:33]);
         chk(addr_s, rows[i][32:17]);
         chk(data_s, rows[i][16:1]);
         chk({15'h0, wide_s}, {15'h0, rows[i][0]});
         ld_exp = (rows[i][56:49] == OPC_POP_A) ? 16'h0006 :
                  (rows[i][56:49] == OPC_POP_B) ? 16'h0005 : 16'h0000;
         chk({13'h0, ld_s}, ld_exp);
         chk({8'h00, flags_out}, 16'h00d5);
         $display("row %0d done", i);
      end
      // Unhandled opcode leaves pointer and memory alone
      run(8'h38);
      chk({15'h0, ill_s}, 16'h0001);
      chk({15'h0, we_s}, 16'h0000);
      chk(ptr_s, 16'hfffe);
      $display("illegal test done");
      // Reset in mid-run returns the pointer to its reset value
      @(posedge mclk);
      rst_n <= 1'b0;
      accum_a <= 8'h9c;
      @(posedge mclk);
      #1 chk(stack_pointer, SP_RESET);
      chk({15'h0, op_ready}, 16'h0000);
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk({15'h0, op_ready}, 16'h0001);
      run(OPC_PUSH_A);
      chk(ptr_s, 16'hffff);
      chk(addr_s, 16'hffff);
      chk(data_s, 16'h009c);
      $display("mid-run reset test done");
      results();
   end
endmodule
